// ---- rtl/mmc_params.svh ----
// Constants of the measurement mode control block: offsets, fields, defaults, timing.
// Assumes a 125 MHz core clock; includers use the macros, the package holds the types.
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH
`define MMC_ADDR_MEAS_CTRL 8'h26
`define MMC_ADDR_ACQ_CTRL 8'h27
`define MMC_MEAS_CTRL_RESET 8'h00
`define MMC_ACQ_CTRL_RESET 8'h00
`define MMC_BIT_ACTIVE 0
`define MMC_BIT_ONE_SHOT 1
`define MMC_BIT_REBOOT 2
`define MMC_OS_LSB 3
`define MMC_BIT_RAW 6
`define MMC_BIT_HEIGHT 7
`define MMC_STEP_LSB 0
`define MMC_BIT_TGT_SRC 4
`define MMC_BIT_LOAD_TGT 5
`define MMC_ACQ_CTRL_MASK 8'h3F
`define MMC_CLOCK_HZ 125000000
`define MMC_MS_PER_S 1000
`define MMC_SPACING_OS0_MS 6
`define MMC_SPACING_OS1_MS 10
`define MMC_SPACING_OS2_MS 8
`define MMC_SPACING_OS3_MS 34
`define MMC_SPACING_OS4_MS 66
`define MMC_SPACING_OS5_MS 130
`define MMC_SPACING_OS6_MS 258
`define MMC_SPACING_OS7_MS 512
`define MMC_REBOOT_CYCLES 8'h10
`endif

// ---- rtl/mmc_pkg.sv ----
// Types shared by the measurement mode control block.
// Assumes nothing beyond the constants header for numeric values.
package mmc_pkg;
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } link_req_t;

   typedef enum logic [3:0] {
      ST_STANDBY = 4'h1,
      ST_ACTIVE = 4'h2,
      ST_ONESHOT = 4'h4,
      ST_REBOOT = 4'h8
   } mode_state_t;

   typedef enum logic [1:0] {
      OUT_BAROMETER = 2'h0,
      OUT_ALTIMETER = 2'h1,
      OUT_RAW = 2'h2
   } out_mode_t;
endpackage

// ---- rtl/measurement_mode_control.sv ----
// Mode and acquisition control: register access from the serial side, standby/active,
// one-shot, soft reboot, sample spacing, periodic interval and alarm target capture.
// Assumes the serial decoder presents byte accesses on link_clock and a converter on clock.
`timescale 1ns/1ns
`include "mmc_params.svh"
module measurement_mode_control #(
   parameter int unsigned TICKS_PER_SECOND = `MMC_CLOCK_HZ,
   parameter int unsigned CYCLES_PER_MS = `MMC_CLOCK_HZ / `MMC_MS_PER_S
) (
   input wire logic clock, // Core clock, 125 MHz.
   input wire logic reset_n, // Power-up reset, asynchronous, active low.
   input wire logic link_clock, // Serial interface clock.
   input wire logic link_req, // One-cycle access request on link_clock.
   input wire mmc_pkg::link_req_t link_access, // Access kind, address and write data.
   output logic link_busy, // Access in flight; requests are ignored.
   output logic link_done, // One-cycle pulse: access finished.
   output logic [7:0] link_rdata, // Read data, valid with link_done.
   input wire logic meas_done, // Converter finished a measurement.
   input wire logic [19:0] meas_pressure, // Pressure or altitude output value.
   input wire logic [11:0] meas_temperature, // Temperature output value.
   input wire logic [15:0] prog_pressure_target, // Programmed pressure target.
   input wire logic [7:0] prog_temperature_target, // Programmed temperature target.
   output logic meas_start, // One-cycle pulse: start a measurement.
   output logic [2:0] oversample_ratio_code, // Oversampling is two to this code.
   output mmc_pkg::out_mode_t out_mode, // Output processing mode.
   output logic alarm_enable, // Alarms, deltas and interrupts allowed.
   output logic [15:0] alarm_pressure_ref, // Pressure reference for alarms.
   output logic [7:0] alarm_temperature_ref, // Temperature reference for alarms.
   output logic device_active, // Device is measuring.
   output logic functional_reset // Soft reboot in progress.
);
   // Link domain.
   mmc_pkg::link_req_t lreq_ff, nxt_lreq;
   logic req_tgl_ff, nxt_req_tgl;
   logic lbusy_ff, nxt_lbusy;
   logic ldone_ff, nxt_ldone;
   logic [7:0] lrdata_ff, nxt_lrdata;
   logic [2:0] ack_sync_ff;
   logic [2:0] rst_sync_ff;
   logic serial_hold;
   // Core domain.
   mmc_pkg::mode_state_t state_ff, nxt_state;
   logic [2:0] req_sync_ff;
   logic ack_tgl_ff, nxt_ack_tgl;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [7:0] meas_ctrl_ff, nxt_meas_ctrl;
   logic [7:0] acq_ctrl_ff, nxt_acq_ctrl;
   logic busy_ff, nxt_busy;
   logic pending_ff, nxt_pending;
   logic [31:0] spacing_ff, nxt_spacing;
   logic [31:0] sec_cycle_ff, nxt_sec_cycle;
   logic [15:0] sec_count_ff, nxt_sec_count;
   logic [7:0] boot_cnt_ff, nxt_boot_cnt;
   logic load_done_ff, nxt_load_done;
   logic [15:0] lat_p_ff, nxt_lat_p;
   logic [7:0] lat_t_ff, nxt_lat_t;
   logic start_ff, nxt_start;
   mmc_pkg::out_mode_t mode_ff, nxt_mode;
   logic alarm_en_ff, nxt_alarm_en;
   logic [15:0] ref_p_ff, nxt_ref_p;
   logic [7:0] ref_t_ff, nxt_ref_t;
   logic active_ff, nxt_active;
   logic reboot_ff, nxt_reboot;
   logic req_evt;

   function automatic logic [31:0] spacing_ms(input logic [2:0] code);
      case (code)
         3'h0: spacing_ms = 32'(`MMC_SPACING_OS0_MS);
         3'h1: spacing_ms = 32'(`MMC_SPACING_OS1_MS);
         3'h2: spacing_ms = 32'(`MMC_SPACING_OS2_MS);
         3'h3: spacing_ms = 32'(`MMC_SPACING_OS3_MS);
         3'h4: spacing_ms = 32'(`MMC_SPACING_OS4_MS);
         3'h5: spacing_ms = 32'(`MMC_SPACING_OS5_MS);
         3'h6: spacing_ms = 32'(`MMC_SPACING_OS6_MS);
         default: spacing_ms = 32'(`MMC_SPACING_OS7_MS);
      endcase
   endfunction

   // The access fields stay frozen until the core acknowledges, so the core may
   // sample them directly once the request toggle has crossed.
   assign serial_hold = rst_sync_ff[1] & rst_sync_ff[2];

   always_comb
   begin
      nxt_lreq = lreq_ff;
      nxt_req_tgl = req_tgl_ff;
      nxt_lbusy = lbusy_ff;
      nxt_ldone = 1'b0;
      nxt_lrdata = lrdata_ff;
      if (lbusy_ff && (ack_sync_ff[1] != ack_sync_ff[2]))
      begin
         nxt_lbusy = 1'b0;
         nxt_ldone = 1'b1;
         nxt_lrdata = rdata_ff;
      end
      else if (!lbusy_ff && link_req && !serial_hold)
      begin
         nxt_lreq = link_access;
         nxt_req_tgl = ~req_tgl_ff;
         nxt_lbusy = 1'b1;
      end
   end

   always_ff @(posedge link_clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lreq_ff <= '0;
         req_tgl_ff <= 1'b0;
         lbusy_ff <= 1'b0;
         ldone_ff <= 1'b0;
         lrdata_ff <= 8'h00;
         ack_sync_ff <= 3'h0;
         rst_sync_ff <= 3'h0;
      end
      else
      begin
         lreq_ff <= nxt_lreq;
         req_tgl_ff <= nxt_req_tgl;
         lbusy_ff <= nxt_lbusy;
         ldone_ff <= nxt_ldone;
         lrdata_ff <= nxt_lrdata;
         ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
         rst_sync_ff <= {rst_sync_ff[1:0], reboot_ff};
      end
   end

   assign link_busy = lbusy_ff;
   assign link_done = ldone_ff;
   assign link_rdata = lrdata_ff;
   assign req_evt = req_sync_ff[1] ^ req_sync_ff[2];

   always_comb
   begin
      nxt_state = state_ff;
      nxt_ack_tgl = ack_tgl_ff;
      nxt_rdata = rdata_ff;
      nxt_meas_ctrl = meas_ctrl_ff;
      nxt_acq_ctrl = acq_ctrl_ff;
      nxt_busy = busy_ff;
      nxt_pending = pending_ff;
      nxt_spacing = (spacing_ff != 32'h0) ? spacing_ff - 32'h1 : 32'h0;
      nxt_sec_cycle = sec_cycle_ff;
      nxt_sec_count = sec_count_ff;
      nxt_boot_cnt = boot_cnt_ff;
      nxt_load_done = load_done_ff;
      nxt_lat_p = lat_p_ff;
      nxt_lat_t = lat_t_ff;
      nxt_start = 1'b0;
      // Converter completion and target capture.
      if (busy_ff && meas_done)
      begin
         nxt_busy = 1'b0;
         if (acq_ctrl_ff[`MMC_BIT_LOAD_TGT] && !load_done_ff)
         begin
            nxt_lat_p = meas_pressure[19:4];
            nxt_lat_t = meas_temperature[11:4];
            nxt_load_done = 1'b1;
         end
      end
      if (!acq_ctrl_ff[`MMC_BIT_LOAD_TGT])
      begin
         nxt_load_done = 1'b0;
      end
      case (state_ff)
         mmc_pkg::ST_STANDBY:
         begin
            nxt_sec_cycle = 32'h0;
            nxt_sec_count = 16'h0000;
            if (meas_ctrl_ff[`MMC_BIT_REBOOT])
            begin
               nxt_state = mmc_pkg::ST_REBOOT;
               nxt_boot_cnt = `MMC_REBOOT_CYCLES;
            end
            else if (meas_ctrl_ff[`MMC_BIT_ACTIVE])
            begin
               nxt_state = mmc_pkg::ST_ACTIVE;
            end
            else if (pending_ff)
            begin
               nxt_state = mmc_pkg::ST_ONESHOT;
            end
         end
         mmc_pkg::ST_ACTIVE:
         begin
            if (meas_ctrl_ff[`MMC_BIT_REBOOT] || !meas_ctrl_ff[`MMC_BIT_ACTIVE])
            begin
               nxt_pending = 1'b0;
               if (!nxt_busy)
               begin
                  nxt_state = mmc_pkg::ST_STANDBY;
               end
            end
            else if (sec_cycle_ff == TICKS_PER_SECOND - 1)
            begin
               nxt_sec_cycle = 32'h0;
               if (sec_count_ff == 16'(16'h0001 << acq_ctrl_ff[3:0]) - 16'h0001)
               begin
                  nxt_sec_count = 16'h0000;
                  nxt_pending = 1'b1;
               end
               else
               begin
                  nxt_sec_count = sec_count_ff + 16'h0001;
               end
            end
            else
            begin
               nxt_sec_cycle = sec_cycle_ff + 32'h1;
            end
         end
         mmc_pkg::ST_ONESHOT:
         begin
            if (!pending_ff && !nxt_busy)
            begin
               nxt_state = mmc_pkg::ST_STANDBY;
               nxt_meas_ctrl[`MMC_BIT_ONE_SHOT] = 1'b0;
            end
            else if (meas_ctrl_ff[`MMC_BIT_REBOOT])
            begin
               nxt_pending = 1'b0;
            end
         end
         mmc_pkg::ST_REBOOT:
         begin
            nxt_pending = 1'b0;
            nxt_boot_cnt = boot_cnt_ff - 8'h01;
            if (boot_cnt_ff == 8'h01)
            begin
               nxt_state = mmc_pkg::ST_STANDBY;
               nxt_meas_ctrl = `MMC_MEAS_CTRL_RESET;
               nxt_acq_ctrl = `MMC_ACQ_CTRL_RESET;
               nxt_load_done = 1'b0;
               nxt_lat_p = 16'h0000;
               nxt_lat_t = 8'h00;
               nxt_spacing = 32'h0;
            end
         end
         default:
         begin
            nxt_state = mmc_pkg::ST_STANDBY;
         end
      endcase
      // One start at a time; until a reboot clears it, the spacing of the code in force at the previous start must run out first.
      // A stop request withdraws the queued start, so none is issued on the way out.
      if (pending_ff && nxt_pending && !busy_ff && spacing_ff == 32'h0
          && !meas_ctrl_ff[`MMC_BIT_REBOOT]
          && (state_ff == mmc_pkg::ST_ACTIVE || state_ff == mmc_pkg::ST_ONESHOT))
      begin
         nxt_start = 1'b1;
         nxt_busy = 1'b1;
         nxt_pending = 1'b0;
         nxt_spacing = 32'(spacing_ms(meas_ctrl_ff[5:3]) * CYCLES_PER_MS);
      end
      // Register access; one that reaches the core during a reboot is answered but has no effect.
      if (req_evt)
      begin
         nxt_ack_tgl = ~ack_tgl_ff;
         nxt_rdata = 8'h00;
         if (state_ff == mmc_pkg::ST_REBOOT)
         begin
            nxt_rdata = 8'h00;
         end
         else if (lreq_ff.addr == `MMC_ADDR_MEAS_CTRL)
         begin
            nxt_rdata = meas_ctrl_ff & 8'hFB;
            if (lreq_ff.write)
            begin
               nxt_meas_ctrl = lreq_ff.wdata;
               // A rising one-shot bit queues exactly one measurement.
               if (lreq_ff.wdata[`MMC_BIT_ONE_SHOT] && !meas_ctrl_ff[`MMC_BIT_ONE_SHOT])
               begin
                  nxt_pending = 1'b1;
               end
            end
         end
         else if (lreq_ff.addr == `MMC_ADDR_ACQ_CTRL)
         begin
            nxt_rdata = acq_ctrl_ff;
            if (lreq_ff.write)
            begin
               nxt_acq_ctrl = lreq_ff.wdata & `MMC_ACQ_CTRL_MASK;
            end
         end
      end
   end

   always_comb
   begin
      nxt_active = (nxt_state == mmc_pkg::ST_ACTIVE) || (nxt_state == mmc_pkg::ST_ONESHOT);
      nxt_reboot = (nxt_state == mmc_pkg::ST_REBOOT);
      nxt_alarm_en = !nxt_meas_ctrl[`MMC_BIT_RAW];
      if (nxt_meas_ctrl[`MMC_BIT_RAW])
      begin
         nxt_mode = mmc_pkg::OUT_RAW;
      end
      else if (nxt_meas_ctrl[`MMC_BIT_HEIGHT])
      begin
         nxt_mode = mmc_pkg::OUT_ALTIMETER;
      end
      else
      begin
         nxt_mode = mmc_pkg::OUT_BAROMETER;
      end
      if (nxt_acq_ctrl[`MMC_BIT_TGT_SRC])
      begin
         nxt_ref_p = nxt_lat_p;
         nxt_ref_t = nxt_lat_t;
      end
      else
      begin
         nxt_ref_p = prog_pressure_target;
         nxt_ref_t = prog_temperature_target;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= mmc_pkg::ST_STANDBY;
         req_sync_ff <= 3'h0;
         ack_tgl_ff <= 1'b0;
         rdata_ff <= 8'h00;
         meas_ctrl_ff <= `MMC_MEAS_CTRL_RESET;
         acq_ctrl_ff <= `MMC_ACQ_CTRL_RESET;
         busy_ff <= 1'b0;
         pending_ff <= 1'b0;
         spacing_ff <= 32'h0;
         sec_cycle_ff <= 32'h0;
         sec_count_ff <= 16'h0000;
         boot_cnt_ff <= 8'h00;
         load_done_ff <= 1'b0;
         lat_p_ff <= 16'h0000;
         lat_t_ff <= 8'h00;
         start_ff <= 1'b0;
         mode_ff <= mmc_pkg::OUT_BAROMETER;
         alarm_en_ff <= 1'b1;
         ref_p_ff <= 16'h0000;
         ref_t_ff <= 8'h00;
         active_ff <= 1'b0;
         reboot_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
         ack_tgl_ff <= nxt_ack_tgl;
         rdata_ff <= nxt_rdata;
         meas_ctrl_ff <= nxt_meas_ctrl;
         acq_ctrl_ff <= nxt_acq_ctrl;
         busy_ff <= nxt_busy;
         pending_ff <= nxt_pending;
         spacing_ff <= nxt_spacing;
         sec_cycle_ff <= nxt_sec_cycle;
         sec_count_ff <= nxt_sec_count;
         boot_cnt_ff <= nxt_boot_cnt;
         load_done_ff <= nxt_load_done;
         lat_p_ff <= nxt_lat_p;
         lat_t_ff <= nxt_lat_t;
         start_ff <= nxt_start;
         mode_ff <= nxt_mode;
         alarm_en_ff <= nxt_alarm_en;
         ref_p_ff <= nxt_ref_p;
         ref_t_ff <= nxt_ref_t;
         active_ff <= nxt_active;
         reboot_ff <= nxt_reboot;
      end
   end

   assign meas_start = start_ff;
   assign oversample_ratio_code = meas_ctrl_ff[5:3];
   assign out_mode = mode_ff;
   assign alarm_enable = alarm_en_ff;
   assign alarm_pressure_ref = ref_p_ff;
   assign alarm_temperature_ref = ref_t_ff;
   assign device_active = active_ff;
   assign functional_reset = reboot_ff;
endmodule

// ---- verification/mode_control_monitor.sv ----
// Port assertions for measurement_mode_control.
// Assumes it is bound into that module and shares its CYCLES_PER_MS.
`timescale 1ns/1ns
module mode_control_monitor #(
   parameter int unsigned CYCLES_PER_MS = 1
) (
   input wire logic clock, // Core clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic link_clock, // Serial side clock.
   input wire logic link_busy, // Access in flight.
   input wire logic link_done, // Access finished.
   input wire logic meas_start, // Measurement start pulse.
   input wire logic [2:0] oversample_ratio_code, // Oversample code.
   input wire mmc_pkg::out_mode_t out_mode, // Output mode.
   input wire logic alarm_enable, // Alarms allowed.
   input wire logic device_active, // Measuring.
   input wire logic functional_reset // Reboot running.
);
   localparam int SPACING_MS [8] = '{6, 10, 8, 34, 66, 130, 258, 512};
   logic [31:0] gap_ff;
   logic [31:0] nxt_gap;
   logic seen_ff;
   logic nxt_seen;
   logic [2:0] code_ff;
   logic [2:0] nxt_code;
   // Cycles since the last start; the first start has no predecessor to keep apart from.
   // The spacing owed is the one of the code in force when the previous start went out.
   always_comb
   begin
      nxt_gap = meas_start ? 32'h1 : gap_ff + 32'h1;
      nxt_seen = seen_ff | meas_start;
      nxt_code = meas_start ? oversample_ratio_code : code_ff;
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gap_ff <= 32'h0;
         seen_ff <= 1'b0;
         code_ff <= 3'h0;
      end
      else
      begin
         gap_ff <= nxt_gap;
         seen_ff <= nxt_seen;
         code_ff <= nxt_code;
      end
   end
   chk_start_spacing: assert property (@(posedge clock) disable iff (!reset_n)
      meas_start && seen_ff |-> gap_ff >= SPACING_MS[code_ff] * CYCLES_PER_MS)
      else $error("start closer than the minimum sample spacing");
   chk_start_pulse: assert property (@(posedge clock) disable iff (!reset_n)
      meas_start |=> !meas_start)
      else $error("start pulse longer than one cycle");
   chk_start_active: assert property (@(posedge clock) disable iff (!reset_n)
      meas_start |-> $past(device_active))
      else $error("start issued while in standby");
   chk_raw_alarm: assert property (@(posedge clock) disable iff (!reset_n)
      alarm_enable == (out_mode != mmc_pkg::OUT_RAW))
      else $error("alarm enable does not follow raw mode");
   chk_reboot_standby: assert property (@(posedge clock) disable iff (!reset_n)
      functional_reset |-> !device_active && !meas_start)
      else $error("reboot while measuring");
   chk_reboot_length: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(functional_reset) |-> functional_reset[*8] ##1 functional_reset[*8]
      ##1 !functional_reset)
      else $error("reboot length wrong");
   chk_reboot_defaults: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(functional_reset) |-> out_mode == mmc_pkg::OUT_BAROMETER
      && oversample_ratio_code == 3'h0 && alarm_enable)
      else $error("outputs not at defaults after reboot");
   chk_link_answer: assert property (@(posedge link_clock) disable iff (!reset_n)
      $rose(link_busy) |-> ##[2:40] link_done)
      else $error("register access never answered");
   cover property (@(posedge clock) meas_start && oversample_ratio_code == 3'h7);
   cover property (@(posedge clock) $fell(functional_reset));
   cover property (@(posedge clock) out_mode == mmc_pkg::OUT_RAW);
endmodule
bind measurement_mode_control mode_control_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) mon_u (
   .clock, .reset_n, .link_clock, .link_busy, .link_done, .meas_start, .oversample_ratio_code,
   .out_mode, .alarm_enable, .device_active, .functional_reset);

// ---- verification/serial_host_model.sv ----
// Host on the serial register side: one byte access at a time.
// Assumes the link port contract; drives at the falling link edge.
`timescale 1ns/1ns
module serial_host_model (
   input wire logic link_clock, // Serial side clock.
   input wire logic link_done, // Access finished.
   input wire logic [7:0] link_rdata, // Read data.
   output logic link_req, // Request pulse.
   output mmc_pkg::link_req_t link_access // Kind, address, data.
);
   int misses;
   initial
   begin
      misses = 0;
      link_req = 1'b0;
      link_access = '0;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      n = 0;
      @(negedge link_clock);
      link_access = '{write: w, addr: a, wdata: d};
      link_req = 1'b1;
      @(negedge link_clock);
      link_req = 1'b0;
      do
      begin
         @(negedge link_clock);
         n++;
      end
      while (link_done !== 1'b1 && n < 60);
      q = link_rdata;
      if (n >= 60)
         misses++;
      @(negedge link_clock);
      // A released bus shows the inverse so a stale copy cannot pass by luck.
      link_access = ~link_access;
   endtask
endmodule

// ---- verification/measurement_mode_control_bench.sv ----
// Self-checking bench: host model, converter model and a register model.
// Assumes short timing: 20 ticks a second, 1 cycle a millisecond.
`timescale 1ns/1ns
module measurement_mode_control_bench;
   localparam int unsigned TPS = 20;
   localparam int unsigned CPM = 1;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic reset_n = 1'b0;
   logic link_req;
   mmc_pkg::link_req_t link_access;
   logic link_busy;
   logic link_done;
   logic [7:0] link_rdata;
   logic meas_done = 1'b0;
   logic [19:0] meas_pressure = 20'h0;
   logic [11:0] meas_temperature = 12'h0;
   logic [15:0] prog_pressure_target = 16'hA5C3;
   logic [7:0] prog_temperature_target = 8'h3C;
   logic meas_start;
   logic [2:0] oversample_ratio_code;
   mmc_pkg::out_mode_t out_mode;
   logic alarm_enable;
   logic [15:0] alarm_pressure_ref;
   logic [7:0] alarm_temperature_ref;
   logic device_active;
   logic functional_reset;
   logic [15:0] seed = 16'h8DD4;
   logic [7:0] meas_m = 8'h00;
   logic [7:0] acq_m = 8'h00;
   logic [31:0] out_q [$];
   time start_q [$];
   int fail_count = 0;
   int cmp_count = 0;
   always #4 clock = ~clock;
   always #15 link_clock = ~link_clock;
   measurement_mode_control #(.TICKS_PER_SECOND(TPS), .CYCLES_PER_MS(CPM)) dut_u (
      .clock, .reset_n, .link_clock, .link_req, .link_access, .link_busy, .link_done,
      .link_rdata, .meas_done, .meas_pressure, .meas_temperature, .prog_pressure_target,
      .prog_temperature_target, .meas_start, .oversample_ratio_code, .out_mode,
      .alarm_enable, .alarm_pressure_ref, .alarm_temperature_ref, .device_active,
      .functional_reset);
   serial_host_model host_u (.link_clock, .link_done, .link_rdata, .link_req, .link_access);
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_u.access(1'b1, a, d, q);
      if (a == 8'h26)
         meas_m = d & 8'hFB;
      if (a == 8'h27)
         acq_m = d & 8'h3F;
      repeat (2) @(negedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      host_u.access(1'b0, a, 8'h00, q);
      check(32'(q), 32'(e));
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Converter: answers each start three cycles later with fresh random outputs.
   initial forever
   begin
      @(negedge clock);
      if (meas_start === 1'b1)
      begin
         start_q.push_back($time);
         repeat (3) @(negedge clock);
         seed = lfsr_next(seed);
         meas_pressure = {seed, seed[15:12]};
         meas_temperature = seed[11:0];
         out_q.push_back({meas_temperature, meas_pressure});
         meas_done = 1'b1;
         @(negedge clock);
         meas_done = 1'b0;
      end
   end
   initial
   begin
      #400000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      logic [7:0] q;
      int n;
      time t0;
      repeat (4) @(negedge clock);
      reset_n = 1'b1;
      repeat (3) @(posedge link_clock);
      rd(8'h26, meas_m);
      rd(8'h30, 8'h00);
      check(32'(out_mode), 32'(mmc_pkg::OUT_BAROMETER));
      seed = lfsr_next(seed);
      wr(8'h27, seed[7:0] & 8'hCF);
      rd(8'h27, acq_m);
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr_next(seed);
         wr(8'h26, {seed[1:0], i[2:0], 3'h0});
         rd(8'h26, meas_m);
         check(32'(oversample_ratio_code), 32'(i));
         check(32'(out_mode), seed[0] ? 32'h2 : 32'(seed[1]));
         check(32'(alarm_enable), 32'(!seed[0]));
      end
      wr(8'h27, 8'h30);
      out_q.delete();
      start_q.delete();
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h26, 8'h3A);
         n = 0;
         do
         begin
            host_u.access(1'b0, 8'h26, 8'h00, q);
            n++;
         end
         while (q[1] === 1'b1 && n < 200);
         meas_m = meas_m & 8'hFD;
         check(32'(q), 32'(meas_m));
         check(32'(device_active), 32'h0);
         check(32'(start_q.size()), 32'(k + 1));
      end
      check(32'(start_q[1] - start_q[0] >= 512 * 8 * CPM), 32'h1);
      check(32'(alarm_pressure_ref), 32'(out_q[0][19:4]));
      check(32'(alarm_temperature_ref), 32'(out_q[0][31:24]));
      wr(8'h27, 8'h00);
      check(32'(alarm_pressure_ref), 32'(prog_pressure_target));
      check(32'(alarm_temperature_ref), 32'(prog_temperature_target));
      wr(8'h26, 8'h00);
      // The last one-shot ran at the slowest code; its spacing must run out first.
      repeat (520) @(negedge clock);
      start_q.delete();
      t0 = $time;
      wr(8'h26, 8'h01);
      repeat (200) @(negedge clock);
      n = start_q.size();
      check(32'(n >= 9 && n <= 11), 32'h1);
      check(32'(start_q[0] - t0 >= 20 * 8), 32'h1);
      wr(8'h26, 8'h03);
      repeat (20) @(negedge clock);
      rd(8'h26, meas_m);
      check(32'(device_active), 32'h1);
      wr(8'h27, 8'h13);
      wr(8'h26, 8'h05);
      n = 0;
      while (functional_reset !== 1'b1 && n < 300)
      begin
         @(negedge clock);
         n++;
      end
      check(32'(device_active), 32'h0);
      while (functional_reset !== 1'b0 && n < 600)
      begin
         @(negedge clock);
         n++;
      end
      repeat (6) @(posedge link_clock);
      meas_m = 8'h00;
      acq_m = 8'h00;
      rd(8'h26, meas_m);
      rd(8'h27, acq_m);
      check(32'(host_u.misses), 32'h0);
      check(32'(link_busy), 32'h0);
      wrap_up();
   end
endmodule
